//--- src/subtract_skip_swap_exec.sv
// instruction execution core for bit skip, subtract and nibble swap, with APB access
`timescale 1ns/1ps
`default_nettype none
`include "subtract_skip_swap_consts.svh"

// Function
// - bit-test skip: selected memory bit set means the next instruction is skipped
// - bit-test skip: tested bit clear means execution simply continues
// - taken skip lasts two instruction cycles, second one a dummy
// - register subtract: work register minus memory byte into work register
// - every subtract sets overflow, zero, half-carry; carry is inverted borrow
// - memory subtract: work minus memory into memory, work register unchanged
// - immediate subtract: work register minus instruction constant into work register
// - nibble exchange swaps low and high halves of a memory byte in place
module subtract_skip_swap_exec
    import subtract_skip_swap_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy,
    output logic             skipNext
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_DUMMY
    } state_t;

    state_t      state_ff;
    logic [1:0]  divCnt_ff;
    logic        cycEn_ff;
    cmd_t        cmd_ff;
    logic [7:0]  work_ff;
    flags_t      flags_ff;
    logic        busy_ff;
    logic        skipPulse_ff;
    logic        lastSkip_ff;
    logic [1:0]  lastCycles_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;

    logic        accessDone;
    logic        apbWrite;
    reg_sel_t    selNow;
    logic        cmdOpValid;
    logic        execNow;
    logic        skipTaken;
    logic [7:0]  memByte;
    logic [7:0]  busByte;
    logic [7:0]  subtrahend;
    logic [7:0]  diff;
    flags_t      subFlags;
    logic        memWrEn;
    logic [3:0]  memWrAddr;
    logic [7:0]  memWrData;
    logic [31:0] rdMux;
    logic        refuse;

    // ======================================================================
    // address decode, shared by read mux and error check
    function automatic reg_sel_t decodeAddr(input logic [7:0] a);
        reg_sel_t s;
        s = SEL_NONE;
        if (a[1:0] != 2'h0) begin
            s = SEL_NONE;
        end else if (a == `OFS_CMD) begin
            s = SEL_CMD;
        end else if (a == `OFS_WORK) begin
            s = SEL_WORK;
        end else if (a == `OFS_FLAGS) begin
            s = SEL_FLAGS;
        end else if (a == `OFS_STAT) begin
            s = SEL_STAT;
        end else if (a[`MEM_SEL_HI:`MEM_SEL_LO] == `MEM_SEL_VAL) begin
            s = SEL_MEM;
        end
        return s;
    endfunction : decodeAddr

    // only the five defined opcodes start an instruction
    function automatic logic isValidOp(input logic [2:0] code);
        return code <= 3'(OP_SWAP);
    endfunction : isValidOp

    // ======================================================================
    // instruction-cycle enable: one mclk pulse every four clocks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            divCnt_ff <= 2'h0;
            cycEn_ff  <= 1'b0;
        end else begin
            divCnt_ff <= (divCnt_ff == `INSTR_DIV) ? 2'h0 : divCnt_ff + 2'h1;
            cycEn_ff  <= (divCnt_ff == `INSTR_DIV);
        end
    end

    // ======================================================================
    // APB handshake terms
    assign accessDone = psel && penable && pready_ff;
    assign apbWrite   = accessDone && pwrite && !pslverr_ff;
    assign selNow     = decodeAddr(paddr);
    assign cmdOpValid = isValidOp(pwdata[`CMD_OP_LO +: 3]);

    // refused: unmapped, read-only status, bad opcode, or any write while busy
    always_comb begin
        refuse = 1'b0;
        if (selNow == SEL_NONE) begin
            refuse = 1'b1;
        end else if (pwrite && (busy_ff || selNow == SEL_STAT)) begin
            refuse = 1'b1;
        end else if (pwrite && selNow == SEL_CMD && !cmdOpValid) begin
            refuse = 1'b1;
        end
    end

    // read data assembled from the addressed register
    always_comb begin
        rdMux = 32'h0000_0000;
        case (selNow)
            SEL_CMD:   rdMux = 32'(cmd_ff);
            SEL_WORK:  rdMux = {24'h00_0000, work_ff};
            SEL_FLAGS: rdMux = {28'h000_0000, flags_ff};
            SEL_STAT: begin
                rdMux[`STAT_BUSY]          = busy_ff;
                rdMux[`STAT_SKIP]          = lastSkip_ff;
                rdMux[`STAT_CYC_LO +: 2]   = lastCycles_ff;
            end
            SEL_MEM:   rdMux = {24'h00_0000, busByte};
            default:   rdMux = 32'h0000_0000;
        endcase
    end

    // answer one cycle into the access phase; data and error latched with it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
        end else if (psel && penable && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= refuse;
            prdata_ff  <= pwrite ? 32'h0000_0000 : rdMux;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    // ======================================================================
    // command capture; a write to the command register starts execution
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmd_ff <= '0;
        end else if (apbWrite && selNow == SEL_CMD) begin
            cmd_ff.op     <= op_t'(pwdata[`CMD_OP_LO +: 3]);
            cmd_ff.bitSel <= pwdata[`CMD_BIT_LO +: 3];
            cmd_ff.addr   <= pwdata[`CMD_ADDR_LO +: 4];
            cmd_ff.imm    <= pwdata[`CMD_IMM_LO +: 8];
        end
    end

    // ======================================================================
    // sequencer: execute on an instruction cycle, add a dummy if skipping
    assign execNow   = (state_ff == ST_EXEC) && cycEn_ff;
    assign skipTaken = (cmd_ff.op == OP_SKIP_IF_BIT_SET) && memByte[cmd_ff.bitSel];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (apbWrite && selNow == SEL_CMD) begin
                        state_ff <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (cycEn_ff) begin
                        state_ff <= skipTaken ? ST_DUMMY : ST_IDLE;
                    end
                end
                ST_DUMMY: begin
                    if (cycEn_ff) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // busy from command acceptance until the last instruction cycle ends
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else if (apbWrite && selNow == SEL_CMD) begin
            busy_ff <= 1'b1;
        end else if (cycEn_ff && ((state_ff == ST_EXEC && !skipTaken) ||
                                  state_ff == ST_DUMMY)) begin
            busy_ff <= 1'b0;
        end
    end

    // skip pulse and record of the last instruction's cost
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            skipPulse_ff  <= 1'b0;
            lastSkip_ff   <= 1'b0;
            lastCycles_ff <= 2'h0;
        end else begin
            skipPulse_ff <= execNow && skipTaken;
            if (execNow) begin
                lastSkip_ff   <= skipTaken;
                lastCycles_ff <= skipTaken ? 2'h2 : 2'h1;
            end
        end
    end

    // ======================================================================
    // datapath: memory and subtractor
    assign subtrahend = (cmd_ff.op == OP_SUB_IMM) ? cmd_ff.imm : memByte;

    sub_unit u_sub (
        .minuend    (work_ff),
        .subtrahend (subtrahend),
        .diff       (diff),
        .flags      (subFlags)
    );

    // exec writes win; bus writes are refused while busy so no clash
    always_comb begin
        memWrEn   = 1'b0;
        memWrAddr = paddr[`MEM_IDX_HI:`MEM_IDX_LO];
        memWrData = pwdata[7:0];
        if (execNow && cmd_ff.op == OP_MINUS_INTO_MEMORY) begin
            memWrEn   = 1'b1;
            memWrAddr = cmd_ff.addr;
            memWrData = diff;
        end else if (execNow && cmd_ff.op == OP_SWAP) begin
            memWrEn   = 1'b1;
            memWrAddr = cmd_ff.addr;
            memWrData = {memByte[3:0], memByte[7:4]};
        end else if (apbWrite && selNow == SEL_MEM) begin
            memWrEn   = 1'b1;
        end
    end

    data_mem u_mem (
        .mclk    (mclk),
        .rst     (rst),
        .wrEn    (memWrEn),
        .wrAddr  (memWrAddr),
        .wrData  (memWrData),
        .rdAddrA (cmd_ff.addr),
        .rdAddrB (paddr[`MEM_IDX_HI:`MEM_IDX_LO]),
        .rdDataA (memByte),
        .rdDataB (busByte)
    );

    // ======================================================================
    // work register: register and immediate subtract results, else software writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            work_ff <= `WORK_RST;
        end else if (execNow && (cmd_ff.op == OP_SUB_WORK || cmd_ff.op == OP_SUB_IMM)) begin
            work_ff <= diff;
        end else if (apbWrite && selNow == SEL_WORK) begin
            work_ff <= pwdata[7:0];
        end
    end

    // flags move on subtracts and software writes; skip and swap keep them
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_ff <= `FLAGS_RST;
        end else if (execNow && (cmd_ff.op == OP_SUB_WORK ||
                                 cmd_ff.op == OP_MINUS_INTO_MEMORY ||
                                 cmd_ff.op == OP_SUB_IMM)) begin
            flags_ff <= subFlags;
        end else if (apbWrite && selNow == SEL_FLAGS) begin
            flags_ff <= pwdata[3:0];
        end
    end

    // ======================================================================
    // outputs straight from flip-flops
    assign prdata   = prdata_ff;
    assign pready   = pready_ff;
    assign pslverr  = pslverr_ff;
    assign busy     = busy_ff;
    assign skipNext = skipPulse_ff;

endmodule : subtract_skip_swap_exec

`default_nettype wire

//--- common/subtract_skip_swap_consts.svh
// offsets, field positions, reset values and timing counts of the execution block
`ifndef SUBTRACT_SKIP_SWAP_CONSTS_SVH
`define SUBTRACT_SKIP_SWAP_CONSTS_SVH

// ==========================================================================
// register byte addresses
`define OFS_CMD        8'h00
`define OFS_WORK       8'h04
`define OFS_FLAGS      8'h08
`define OFS_STAT       8'h0c
`define OFS_MEM_BASE   8'h40
`define MEM_SEL_HI     7
`define MEM_SEL_LO     6
`define MEM_SEL_VAL    2'h1
`define MEM_IDX_HI     5
`define MEM_IDX_LO     2

// ==========================================================================
// command word fields
`define CMD_OP_LO      0
`define CMD_BIT_LO     4
`define CMD_ADDR_LO    8
`define CMD_IMM_LO     16

// ==========================================================================
// flag and status bit positions
`define FLG_CARRY      0
`define FLG_HALF       1
`define FLG_ZERO       2
`define FLG_OVER       3
`define STAT_BUSY      0
`define STAT_SKIP      1
`define STAT_CYC_LO    4

// ==========================================================================
// reset values and timing
`define WORK_RST       8'h00
`define FLAGS_RST      4'h0
`define INSTR_DIV      2'h3

`endif

//--- common/subtract_skip_swap_pkg.sv
// types shared by the execution block and its sub-modules
`default_nettype none

package subtract_skip_swap_pkg;

    // ======================================================================
    // instruction kinds
    typedef enum logic [2:0] {
        OP_SKIP_IF_BIT_SET,
        OP_SUB_WORK,
        OP_MINUS_INTO_MEMORY,
        OP_SUB_IMM,
        OP_SWAP
    } op_t;

    // ======================================================================
    // status flags
    typedef struct packed {
        logic signedRangeExceedBit;
        logic zero;
        logic halfCarry;
        logic carry;
    } flags_t;

    // ======================================================================
    // one decoded instruction
    typedef struct packed {
        logic [7:0] imm;
        logic [3:0] addr;
        logic [2:0] bitSel;
        op_t        op;
    } cmd_t;

    // register selection by address
    typedef enum logic [2:0] {
        SEL_CMD,
        SEL_WORK,
        SEL_FLAGS,
        SEL_STAT,
        SEL_MEM,
        SEL_NONE
    } reg_sel_t;

endpackage : subtract_skip_swap_pkg

`default_nettype wire

//--- src/sub_unit.sv
// 8-bit subtractor with overflow, zero, half-carry and carry results
`timescale 1ns/1ps
`default_nettype none

module sub_unit
    import subtract_skip_swap_pkg::*;
(
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    output logic      [7:0] diff,
    output flags_t          flags
);

    logic [8:0] wide;
    logic [4:0] low;

    // add the inverse plus one: carry out is the inverted borrow
    always_comb begin
        wide = {1'b0, minuend} + {1'b0, ~subtrahend} + 9'h001;
        low  = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + 5'h01;
        diff = wide[7:0];
        flags.carry                = wide[8];
        flags.halfCarry            = low[4];
        flags.zero                 = (wide[7:0] == 8'h00);
        flags.signedRangeExceedBit = (minuend[7] != subtrahend[7])
                                   && (wide[7] != minuend[7]);
    end

endmodule : sub_unit

`default_nettype wire

//--- src/data_mem.sv
// sixteen-byte data memory in flip-flops, one write port, two read ports
`timescale 1ns/1ps
`default_nettype none

module data_mem (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       wrEn,
    input  wire logic [3:0] wrAddr,
    input  wire logic [7:0] wrData,
    input  wire logic [3:0] rdAddrA,
    input  wire logic [3:0] rdAddrB,
    output logic      [7:0] rdDataA,
    output logic      [7:0] rdDataB
);

    logic [7:0] mem_ff [16];

    // ======================================================================
    // one flip-flop byte per location
    genvar i;
    generate
        for (i = 0; i < 16; i++) begin : g_byte
            always_ff @(posedge mclk or posedge rst) begin
                if (rst) begin
                    mem_ff[i] <= 8'h00;
                end else if (wrEn && (wrAddr == 4'(i))) begin
                    mem_ff[i] <= wrData;
                end
            end
        end
    endgenerate

    // reads are combinational so the exec cycle sees the byte at once
    assign rdDataA = mem_ff[rdAddrA];
    assign rdDataB = mem_ff[rdAddrB];

endmodule : data_mem

`default_nettype wire

//--- test/subtract_skip_swap_exec_assertions.sv
// checker for bus handshake and execution timing at the block's ports
`timescale 1ns/1ps
`default_nettype none

module subtract_skip_swap_exec_chk (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        busy,
    input wire logic        skipNext
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // ======================================================================
    // transfer steps
    sequence accessWait;
        psel && penable && !pready;
    endsequence
    sequence cmdCommit;
        psel && penable && pready && pwrite && paddr == 8'h00 && !pslverr;
    endsequence
    sequence busyWrite;
        psel && penable && pready && pwrite && busy;
    endsequence

    // ======================================================================
    // handshake and execution properties
    chk_ready_after_wait: assert property (accessWait |=> pready)
        else $error("pready missing after first access cycle");
    chk_ready_one_cycle: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_busy_after_cmd: assert property (cmdCommit |=> busy)
        else $error("busy did not rise after command");
    chk_busy_write_refused: assert property (busyWrite |-> pslverr)
        else $error("write accepted while busy");
    chk_skip_when_busy: assert property (skipNext |-> busy)
        else $error("skip outside an instruction");
    chk_skip_pulse_once: assert property (skipNext |=> !skipNext)
        else $error("skip pulse too long");
    chk_skip_dummy_cycle: assert property ($rose(skipNext) |-> busy[*3])
        else $error("dummy cycle missing after skip");
    chk_busy_bounded: assert property ($rose(busy) |-> ##[1:9] !busy)
        else $error("instruction runs too long");
    chk_unmapped_zero: assert property (psel && penable && pready && paddr == 8'h20
        |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_bad_op_refused: assert property (psel && penable && pready && pwrite
        && paddr == 8'h00 && pwdata[2:0] > 3'h4 |-> pslverr)
        else $error("invalid opcode accepted");
endmodule : subtract_skip_swap_exec_chk

bind subtract_skip_swap_exec subtract_skip_swap_exec_chk u_chk (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy), .skipNext(skipNext)
);

`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the subtract, skip and swap execution block
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import subtract_skip_swap_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic        skipNext;
    logic [31:0] rd;
    integer      n_mismatch = 0;
    integer      compares = 0;
    integer      seed = 32'hd164;
    integer      skips = 0;
    integer      busyCyc = 0;

    subtract_skip_swap_exec dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .busy(busy), .skipNext(skipNext));

    // ======================================================================
    // clock, watchdog and cycle monitor
    always #5 mclk = ~mclk;

    // watchdog: a hang counts as a mismatch
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end

    // count busy cycles and skip pulses of the current instruction
    always @(posedge mclk) begin
        if (skipNext === 1'b1) skips++;
        if (busy === 1'b1) busyCyc++;
    end

    // ======================================================================
    // helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // one transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
        integer n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        check({31'h0, pslverr}, {31'h0, ee}, "slverr");
        check({31'h0, n < 20}, 32'h1, "pready");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // waits for the instruction started at the last commit
    task automatic waitIdle;
        integer n;
        repeat (2) @(posedge mclk);
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        check({31'h0, n < 20}, 32'h1, "idle");
    endtask : waitIdle

    // flags {ov, z, half, carry}; carry and half are inverted borrows
    function automatic logic [3:0] subFlags(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        return {(a[7] != b[7]) && (d[7] != a[7]), d == 8'h00, a[3:0] >= b[3:0], a >= b};
    endfunction : subFlags

    // runs one instruction and compares all results against the model
    task automatic runOne(input logic [2:0] op, input logic [7:0] w, input logic [7:0] m,
                          input logic [7:0] imm, input logic [3:0] a, input logic [2:0] b,
                          input logic [3:0] f);
        logic [7:0] expW;
        logic [7:0] expM;
        logic [3:0] expF;
        logic       sk;
        logic [7:0] ma;
        expW = w;
        expM = m;
        expF = f;
        sk = 1'b0;
        ma = 8'h40 + {2'b00, a, 2'b00};
        case (op)
            3'h0: sk = m[b];
            3'h1: begin expW = w - m; expF = subFlags(w, m); end
            3'h2: begin expM = w - m; expF = subFlags(w, m); end
            3'h3: begin expW = w - imm; expF = subFlags(w, imm); end
            default: expM = {m[3:0], m[7:4]};
        endcase
        apb(1'b1, 8'h04, {24'h0, w}, 1'b0);
        apb(1'b1, ma, {24'h0, m}, 1'b0);
        apb(1'b1, 8'h08, {28'h0, f}, 1'b0);
        apb(1'b1, 8'h00, {8'h0, imm, 4'h0, a, 1'b0, b, 1'b0, op}, 1'b0);
        skips = 0;
        busyCyc = 0;
        waitIdle();
        check({31'h0, sk ? (busyCyc >= 5 && busyCyc <= 8) : (busyCyc <= 4)}, 32'h1, "cyc");
        check(skips, {31'h0, sk}, "skip pulse");
        apb(1'b0, 8'h04, 32'h0, 1'b0);
        check(rd, {24'h0, expW}, "work");
        apb(1'b0, ma, 32'h0, 1'b0);
        check(rd, {24'h0, expM}, "mem");
        apb(1'b0, 8'h08, 32'h0, 1'b0);
        check(rd, {28'h0, expF}, "flags");
        apb(1'b0, 8'h0c, 32'h0, 1'b0);
        check({30'h0, rd[5:4]}, sk ? 32'h2 : 32'h1, "stat cycles");
        check({31'h0, rd[1]}, {31'h0, sk}, "stat skip");
        // command register reads back its packed fields, upper bits zero
        apb(1'b0, 8'h00, 32'h0, 1'b0);
        check(rd, {14'h0, imm, a, b, op}, "cmd readback");
    endtask : runOne

    // ======================================================================
    // main sequence: reset values, corners, random, refusals
    initial begin
        logic [31:0] r;
        logic [31:0] q;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        apb(1'b0, 8'h04, 32'h0, 1'b0);
        check(rd, 32'h0, "work reset");
        apb(1'b0, 8'h7c, 32'h0, 1'b0);
        check(rd, 32'h0, "mem reset");
        for (int i = 0; i < 36; i++) begin
            r = $random(seed);
            q = $random(seed);
            case (i)
                0: runOne(3'h1, 8'h5a, 8'h5a, 8'h00, 4'h3, 3'h0, 4'h0);
                1: runOne(3'h3, 8'h00, 8'h00, 8'h01, 4'h0, 3'h0, 4'hf);
                2: runOne(3'h2, 8'h80, 8'h01, 8'h00, 4'hf, 3'h0, 4'h0);
                3: runOne(3'h0, 8'h33, 8'h80, 8'h00, 4'h1, 3'h7, 4'ha);
                4: runOne(3'h0, 8'h33, 8'h7f, 8'h00, 4'h2, 3'h7, 4'h5);
                5: runOne(3'h4, 8'h00, 8'ha5, 8'h00, 4'h4, 3'h0, 4'h9);
                default: runOne(3'(q[15:0] % 5), r[7:0], r[15:8], r[23:16], r[27:24],
                                r[30:28], q[23:20]);
            endcase
        end
        // refusals leave the state untouched
        apb(1'b1, 8'h0c, 32'h3, 1'b1);
        apb(1'b0, 8'h20, 32'h0, 1'b1);
        check(rd, 32'h0, "unmapped read");
        apb(1'b1, 8'h02, 32'h1, 1'b1);
        apb(1'b1, 8'h00, 32'h5, 1'b1);
        @(posedge mclk);
        check({31'h0, busy}, 32'h0, "bad op ran");
        apb(1'b1, 8'h04, 32'h11, 1'b0);
        apb(1'b1, 8'h40, 32'h01, 1'b0);
        apb(1'b1, 8'h00, 32'h0, 1'b0);
        apb(1'b1, 8'h04, 32'h99, 1'b1);
        waitIdle();
        apb(1'b0, 8'h04, 32'h0, 1'b0);
        check(rd, 32'h11, "write while busy");
        finish_test();
    end

    // ======================================================================
    // verdict
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
endmodule : tb_top

`default_nettype wire
